// ---- rtl/sidbc_regs.svh ----
`ifndef SIDBC_REGS_SVH
`define SIDBC_REGS_SVH

// Register indices on the serial bus
`define SIDBC_IDX_REV_MAKER   8'h05
`define SIDBC_IDX_CLASS_PART  8'h06
`define SIDBC_IDX_RB_LEN      8'h07

// Readback-length field layout and reset value
`define SIDBC_RB_LEN_MSB      4
`define SIDBC_RB_LEN_RESET    5'h08
`define SIDBC_RB_RSVD_ZERO    3'h0

// Class code for a fanout-only buffer without a PLL
`define SIDBC_CLASS_FANOUT    2'h3

// Byte framing
`define SIDBC_BITS_PER_BYTE   4'h8
`define SIDBC_LAST_TX_BIT     4'h7
`define SIDBC_IDLE_BYTE       8'hff
`define SIDBC_UNMAPPED_BYTE   8'h00

// Write phases: index byte, count byte, data bytes
`define SIDBC_PH_INDEX        2'h0
`define SIDBC_PH_COUNT        2'h1
`define SIDBC_PH_DATA         2'h2

`endif

// ---- rtl/sidbc_pkg.sv ----
package sidbc_pkg;

  typedef logic [7:0] sidbc_byte_t;
  typedef logic [4:0] sidbc_len_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ACK,
    ST_RX,
    ST_TX,
    ST_RACK
  } sidbc_state_t;

  typedef struct packed {
    sidbc_state_t st;
    logic         scl_q;
    logic         sda_q;
    sidbc_byte_t  shift;
    logic [3:0]   bitcnt;
    logic         rw;
    logic [1:0]   phase;
    sidbc_byte_t  idx;
    logic [5:0]   sent;
    logic         hack;
    logic         oe_b;
    logic         sda_out;
    logic         wr_en;
    sidbc_byte_t  wr_addr;
    sidbc_byte_t  wr_data;
  } sidbc_eng_t;

  typedef struct packed {
    sidbc_len_t  len;
    sidbc_byte_t rdata;
  } sidbc_bank_t;

endpackage : sidbc_pkg

// ---- rtl/sidbc_bank.sv ----
`timescale 1ns/1ns
`include "sidbc_regs.svh"

module sidbc_bank #(
  parameter logic [3:0] REV_ID     = 4'h2,                 // Arbitrary value
  parameter logic [3:0] MAKER_ID   = 4'h5,                 // Arbitrary value
  parameter logic [1:0] CLASS_CODE = `SIDBC_CLASS_FANOUT,
  parameter logic [5:0] PART_ID    = 6'h15                 // Arbitrary value
) (
  input  wire logic                CLOCK,
  input  wire logic                RST_B,
  input  wire logic                wr_en,
  input  wire sidbc_pkg::sidbc_byte_t wr_addr,
  input  wire sidbc_pkg::sidbc_byte_t wr_data,
  input  wire sidbc_pkg::sidbc_byte_t rd_addr,
  output sidbc_pkg::sidbc_byte_t   rd_data,
  output sidbc_pkg::sidbc_len_t    rb_len
);
  import sidbc_pkg::*;

  sidbc_bank_t r_q;
  sidbc_bank_t r_d;

  always_comb begin
    r_d = r_q;
    // Only the length field takes writes; identity bytes and reserved bits ignore them
    if (wr_en && wr_addr == `SIDBC_IDX_RB_LEN) begin
      r_d.len = wr_data[`SIDBC_RB_LEN_MSB:0];
    end
    case (rd_addr)
      `SIDBC_IDX_REV_MAKER:  r_d.rdata = {REV_ID, MAKER_ID};
      `SIDBC_IDX_CLASS_PART: r_d.rdata = {CLASS_CODE, PART_ID};
      `SIDBC_IDX_RB_LEN:     r_d.rdata = {`SIDBC_RB_RSVD_ZERO, r_q.len};
      default:               r_d.rdata = `SIDBC_UNMAPPED_BYTE;
    endcase
  end

  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      r_q.len   <= `SIDBC_RB_LEN_RESET;
      r_q.rdata <= `SIDBC_UNMAPPED_BYTE;
    end else begin
      r_q <= r_d;
    end
  end

  assign rd_data = r_q.rdata;
  assign rb_len  = r_q.len;

endmodule : sidbc_bank

// ---- rtl/sidbc_top.sv ----
// Notes on behaviour
// - Index 5 reads revision and maker nibbles.
// - Index 6 reads class code and part code.
// - Class code is constant, 11 means fanout.
// - Index 7 holds five-bit length, top reserved.
// - Written length sets later block read size.
// - Length resets to eight bytes.
// - Block read sends count, then consecutive bytes.
`timescale 1ns/1ns
`include "sidbc_regs.svh"

module sidbc_top #(
  parameter logic [6:0] SLAVE_ADDR = 7'h2c,
  parameter logic [3:0] REV_ID     = 4'h2,    // Arbitrary value
  parameter logic [3:0] MAKER_ID   = 4'h5,    // Arbitrary value
  parameter logic [5:0] PART_ID    = 6'h15    // Arbitrary value
) (
  input  wire logic             CLOCK,
  input  wire logic             RST_B,
  input  wire logic             SCL,
  input  wire logic             SDA_IN,
  output logic                  SDA_OUT,
  output logic                  SDA_OE_B,
  output sidbc_pkg::sidbc_len_t READBACK_LEN
);
  import sidbc_pkg::*;

  sidbc_eng_t  r_q;
  sidbc_eng_t  r_d;
  sidbc_byte_t rd_data;
  sidbc_len_t  rb_len;
  logic        scl_rise;
  logic        scl_fall;
  logic        start_seen;
  logic        stop_seen;

  // Open-drain: releasing the line is the same as sending a one
  function automatic logic drive_bit(input sidbc_byte_t b);
    drive_bit = b[7];
  endfunction : drive_bit

  // Ones fill in behind, so an exhausted shifter leaves the line free
  function automatic sidbc_byte_t shift_up(input sidbc_byte_t b);
    shift_up = {b[6:0], 1'b1};
  endfunction : shift_up

  // Index wraps at eight bits; high indices read as unmapped
  function automatic sidbc_byte_t next_idx(input sidbc_byte_t i);
    next_idx = i + 8'h01;
  endfunction : next_idx

  function automatic sidbc_byte_t count_byte(input sidbc_len_t n);
    count_byte = {`SIDBC_RB_RSVD_ZERO, n};
  endfunction : count_byte

  function automatic logic more_data(input logic [5:0] sent, input sidbc_len_t n);
    more_data = (sent < {1'b0, n});
  endfunction : more_data

  function automatic logic addr_hit(input sidbc_byte_t b, input logic [6:0] a);
    addr_hit = (b[7:1] == a);
  endfunction : addr_hit

  // SDA moving while SCL is high on both samples is a start or a stop
  function automatic logic sda_edge(input logic c, input logic c_q, input logic s_q,
                                    input logic s);
    sda_edge = c & c_q & (s_q != s);
  endfunction : sda_edge

  sidbc_bank #(
    .REV_ID     (REV_ID),
    .MAKER_ID   (MAKER_ID),
    .CLASS_CODE (`SIDBC_CLASS_FANOUT),
    .PART_ID    (PART_ID)
  ) u_sidbc_bank (
    .CLOCK   (CLOCK),
    .RST_B   (RST_B),
    .wr_en   (r_q.wr_en),
    .wr_addr (r_q.wr_addr),
    .wr_data (r_q.wr_data),
    .rd_addr (r_q.idx),
    .rd_data (rd_data),
    .rb_len  (rb_len)
  );

  // Pins are synchronous to CLOCK; edges seen against last sample
  assign scl_rise   = SCL & ~r_q.scl_q;
  assign scl_fall   = ~SCL & r_q.scl_q;
  assign start_seen = sda_edge(SCL, r_q.scl_q, r_q.sda_q, SDA_IN) & ~SDA_IN;
  assign stop_seen  = sda_edge(SCL, r_q.scl_q, r_q.sda_q, SDA_IN) & SDA_IN;

  always_comb begin
    r_d         = r_q;
    r_d.scl_q   = SCL;
    r_d.sda_q   = SDA_IN;
    r_d.wr_en   = 1'b0;
    r_d.sda_out = 1'b0;
    if (start_seen) begin
      // Repeated start keeps the index so a read follows the written one
      r_d.st     = ST_ADDR;
      r_d.bitcnt = 4'h0;
      r_d.phase  = `SIDBC_PH_INDEX;
      r_d.oe_b   = 1'b1;
    end else if (stop_seen) begin
      r_d.st   = ST_IDLE;
      r_d.oe_b = 1'b1;
    end else begin
      case (r_q.st)
        ST_IDLE: begin
          r_d.oe_b = 1'b1;
        end
        ST_ADDR, ST_RX: begin
          if (scl_rise) begin
            r_d.shift  = {r_q.shift[6:0], SDA_IN};
            r_d.bitcnt = r_q.bitcnt + 4'h1;
          end else if (scl_fall && r_q.bitcnt == `SIDBC_BITS_PER_BYTE) begin
            r_d.bitcnt = 4'h0;
            if (r_q.st == ST_ADDR) begin
              if (addr_hit(r_q.shift, SLAVE_ADDR)) begin
                r_d.rw   = r_q.shift[0];
                r_d.oe_b = 1'b0;
                r_d.st   = ST_ACK;
              end else begin
                r_d.st = ST_IDLE;
              end
            end else begin
              // Every received byte is acknowledged, mapped or not
              r_d.oe_b = 1'b0;
              r_d.st   = ST_ACK;
              case (r_q.phase)
                `SIDBC_PH_INDEX: begin
                  r_d.idx   = r_q.shift;
                  r_d.phase = `SIDBC_PH_COUNT;
                end
                `SIDBC_PH_COUNT: begin
                  r_d.phase = `SIDBC_PH_DATA;
                end
                default: begin
                  r_d.wr_en   = 1'b1;
                  r_d.wr_addr = r_q.idx;
                  r_d.wr_data = r_q.shift;
                  r_d.idx     = next_idx(r_q.idx);
                end
              endcase
            end
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            r_d.bitcnt = 4'h0;
            if (r_q.rw) begin
              // Count byte goes first on every block read
              r_d.shift = count_byte(rb_len);
              r_d.sent  = 6'h00;
              r_d.oe_b  = drive_bit(count_byte(rb_len));
              r_d.st    = ST_TX;
            end else begin
              r_d.oe_b = 1'b1;
              r_d.st   = ST_RX;
            end
          end
        end
        ST_TX: begin
          if (scl_fall) begin
            if (r_q.bitcnt == `SIDBC_LAST_TX_BIT) begin
              r_d.oe_b   = 1'b1;
              r_d.bitcnt = 4'h0;
              r_d.st     = ST_RACK;
            end else begin
              r_d.shift  = shift_up(r_q.shift);
              r_d.oe_b   = drive_bit(shift_up(r_q.shift));
              r_d.bitcnt = r_q.bitcnt + 4'h1;
            end
          end
        end
        ST_RACK: begin
          if (scl_rise) begin
            r_d.hack = ~SDA_IN;
          end else if (scl_fall) begin
            if (r_q.hack) begin
              r_d.st = ST_TX;
              // Beyond the programmed length the line is left released
              if (more_data(r_q.sent, rb_len)) begin
                r_d.shift = rd_data;
                r_d.oe_b  = drive_bit(rd_data);
                r_d.idx   = next_idx(r_q.idx);
                r_d.sent  = r_q.sent + 6'h01;
              end else begin
                r_d.shift = `SIDBC_IDLE_BYTE;
                r_d.oe_b  = 1'b1;
              end
            end else begin
              // Host not-acknowledge ends the read; wait for stop
              r_d.st = ST_IDLE;
            end
          end
        end
        default: begin
          r_d.st   = ST_IDLE;
          r_d.oe_b = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      r_q         <= '0;
      r_q.st      <= ST_IDLE;
      r_q.scl_q   <= 1'b1;
      r_q.sda_q   <= 1'b1;
      r_q.oe_b    <= 1'b1;
      r_q.phase   <= `SIDBC_PH_INDEX;
    end else begin
      r_q <= r_d;
    end
  end

  assign SDA_OUT      = r_q.sda_out;
  assign SDA_OE_B     = r_q.oe_b;
  assign READBACK_LEN = rb_len;

endmodule : sidbc_top

// ---- testbench/sidbc_top_chk.sv ----
`timescale 1ns/1ns
module sidbc_top_chk (
  input wire logic                  CLOCK,
  input wire logic                  RST_B,
  input wire logic                  SCL,
  input wire logic                  SDA_IN,
  input wire logic                  SDA_OUT,
  input wire logic                  SDA_OE_B,
  input wire sidbc_pkg::sidbc_len_t READBACK_LEN
);
  import sidbc_pkg::*;
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RST_B);
  property p_drive_zero; !SDA_OUT; endproperty
  a_drive_zero: assert property (p_drive_zero) else $error("drive high");
  property p_len_reset; !$past(RST_B) |-> READBACK_LEN == 5'h08; endproperty
  a_len_reset: assert property (p_len_reset) else $error("len reset");
  property p_len_scl; $changed(READBACK_LEN) |-> !SCL && !$past(SCL); endproperty
  a_len_scl: assert property (p_len_scl) else $error("len moved");
  property p_oe_fall; $fell(SDA_OE_B) |-> !SCL && !$past(SCL); endproperty
  a_oe_fall: assert property (p_oe_fall) else $error("drive early");
  property p_oe_rise; $rose(SDA_OE_B) |-> !SCL && !$past(SCL); endproperty
  a_oe_rise: assert property (p_oe_rise) else $error("release early");
  property p_oe_hold; !SDA_OE_B && SCL |=> !SDA_OE_B; endproperty
  a_oe_hold: assert property (p_oe_hold) else $error("bit not held");
  property p_oe_bound; $fell(SDA_OE_B) |-> ##[1:200] SDA_OE_B; endproperty
  a_oe_bound: assert property (p_oe_bound) else $error("drive stuck");
  property p_no_start; SCL && $past(SCL) && $fell(SDA_IN) |-> SDA_OE_B; endproperty
  a_no_start: assert property (p_no_start) else $error("false start");
endmodule : sidbc_top_chk
bind sidbc_top sidbc_top_chk u_sidbc_top_chk (
  .CLOCK(CLOCK), .RST_B(RST_B), .SCL(SCL), .SDA_IN(SDA_IN),
  .SDA_OUT(SDA_OUT), .SDA_OE_B(SDA_OE_B), .READBACK_LEN(READBACK_LEN));

// ---- testbench/sidbc_host.sv ----
`timescale 1ns/1ns
module sidbc_host (
  input  wire logic clk,
  input  wire logic sda_w,
  output logic      scl,
  output logic      sda
);
  initial scl = 1'b1;
  initial sda = 1'b1;
  // Four cycles a phase, above the three-cycle minimum
  task step(input logic c, input logic v);
    scl = c;
    sda = v;
    repeat (4) @(posedge clk);
    #1;
  endtask : step
  task start;
    step(scl, 1'b1);
    step(1'b1, 1'b1);
    step(1'b1, 1'b0);
    step(1'b0, 1'b0);
  endtask : start
  task stop;
    step(1'b0, 1'b0);
    step(1'b1, 1'b0);
    step(1'b1, 1'b1);
  endtask : stop
  // Data moves only while the clock is low
  task xb(input logic [8:0] v, output logic [8:0] q);
    for (int i = 8; i >= 0; i--) begin
      step(1'b0, v[i]);
      step(1'b1, v[i]);
      q[i] = sda_w;
    end
    step(1'b0, 1'b1);
  endtask : xb
endmodule : sidbc_host

// ---- testbench/sidbc_top_bench.sv ----
`timescale 1ns/1ns
module sidbc_top_bench;
  import sidbc_pkg::*;
  localparam logic [6:0] DEV_ADDR = 7'h3a;
  logic        clock, rst_b, scl, sda_h, sda_out, sda_oe_b, sda_w;
  sidbc_len_t  len;
  logic [8:0]  r;
  logic [7:0]  lenv;
  logic [23:0] d;
  int          fails, total_checks;
  // Open drain: only a low drive wins
  assign sda_w = sda_h & (sda_oe_b | sda_out);
  // Id values arbitrary
  sidbc_top #(.SLAVE_ADDR(DEV_ADDR), .REV_ID(4'h9), .MAKER_ID(4'h3),
              .PART_ID(6'h2a)) u_sidbc_top (
    .CLOCK(clock), .RST_B(rst_b), .SCL(scl), .SDA_IN(sda_w),
    .SDA_OUT(sda_out), .SDA_OE_B(sda_oe_b), .READBACK_LEN(len));
  sidbc_host u_sidbc_host (.clk(clock), .sda_w(sda_w), .scl(scl), .sda(sda_h));
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  task chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  function automatic logic [7:0] exp_b(input logic [7:0] i);
    case (i)
      8'h05: return 8'h93;
      8'h06: return 8'hea;
      8'h07: return lenv;
      default: return 8'h00;
    endcase
  endfunction : exp_b
  task send(input logic [7:0] b, input logic nak);
    u_sidbc_host.xb({b, 1'b1}, r);
    chk({7'h0, r[0]}, {7'h0, nak});
  endtask : send
  // Index, ignored count, then bytes to 5, 6 and 7
  task wr(input logic [23:0] v);
    u_sidbc_host.start;
    send({DEV_ADDR, 1'b0}, 1'b0);
    send(8'h05, 1'b0);
    send(8'h03, 1'b0);
    for (int k = 2; k >= 0; k--) send(v[k*8 +: 8], 1'b0);
    u_sidbc_host.stop;
  endtask : wr
  task rd(input logic [7:0] idx);
    int n;
    n = int'(lenv) + 2;
    u_sidbc_host.start;
    send({DEV_ADDR, 1'b0}, 1'b0);
    send(idx, 1'b0);
    u_sidbc_host.start;
    send({DEV_ADDR, 1'b1}, 1'b0);
    u_sidbc_host.xb(9'h1fe, r);
    chk(r[8:1], lenv);
    for (int k = 0; k < n; k++) begin
      u_sidbc_host.xb({8'hff, 1'(k == n - 1)}, r);
      chk(r[8:1], (k < int'(lenv)) ? exp_b(idx + 8'(k)) : 8'hff);
    end
    u_sidbc_host.stop;
  endtask : rd
  task test_done;
    $display("checks %0d fails %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : test_done
  initial begin
    repeat (100000) @(posedge clock);
    fails++;
    test_done;
  end
  initial begin
    rst_b = 1'b0;
    lenv = 8'h08;
    fails = 0;
    total_checks = 0;
    void'($urandom(17));
    repeat (5) @(posedge clock);
    #1 rst_b = 1'b1;
    chk({3'h0, len}, 8'h08);
    rd(8'h05);
    u_sidbc_host.start;
    send({DEV_ADDR ^ 7'h01, 1'b0}, 1'b1);
    u_sidbc_host.stop;
    // Corners: zero with reserved bits set, then the largest length
    for (int j = 0; j < 5; j++) begin
      d = 24'($urandom);
      if (j == 0) d[7:0] = 8'he0;
      if (j == 1) d[7:0] = 8'h1f;
      wr(d);
      lenv = {3'h0, d[4:0]};
      chk({3'h0, len}, lenv);
      rd(8'h05 + 8'(j % 3));
    end
    test_done;
  end
endmodule : sidbc_top_bench
